/* File: rtl/aso_defs.svh */
// register offsets, field positions and reset values of the output block
`ifndef ASO_DEFS_SVH
`define ASO_DEFS_SVH

`define ASO_OFS_CTRL     12'h000
`define ASO_OFS_CMD      12'h004
`define ASO_OFS_STATUS   12'h008

`define ASO_CTRL_W       13
`define ASO_CTRL_SYNC_EN 0
`define ASO_CTRL_SDR     1
`define ASO_CTRL_LANES   3:2
`define ASO_CTRL_RES     5:4
`define ASO_CTRL_OFS_A   6
`define ASO_CTRL_OFS_B   7
`define ASO_CTRL_DEC_EN  8
`define ASO_CTRL_CPLX    9
`define ASO_CTRL_DEC_LOG 12:10
`define ASO_CTRL_RESET   13'h0420

`define ASO_CMD_SYNC     0
`define ASO_CMD_MIX      1

`define ASO_ST_SEEN      0

`define ASO_LANE_TWO     2'h0
`define ASO_LANE_ONE     2'h1
`define ASO_LANE_HALF    2'h2

`define ASO_RES_14       2'h0
`define ASO_RES_18       2'h2
`define ASO_RES_MIN      7'h0E

`define ASO_WORD_W       20
`define ASO_SH_W         80

`endif

/* File: rtl/aso_pkg.sv */
// types shared by the serial output block
package aso_pkg;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } aso_ser_t;

    typedef struct packed {
        aso_ser_t              ser;
        logic [12:0]           ctrl;
        logic                  pin_q;
        logic                  pin_prev;
        logic                  pd;
        logic                  sync_p;
        logic                  nco_p;
        logic                  seen;
        logic [4:0]            div_cnt;
        logic                  sci_q;
        logic                  bit_clk;
        logic                  frm_clk;
        logic [3:0]            lanes;
        logic [3:0][79:0]      sh;
        logic [6:0]            bit_cnt;
        logic [6:0]            frame_bits;
        logic                  word_cnt;
        logic [1:0][1:0][19:0] coll;
        logic [1:0][1:0][19:0] hold;
        logic [31:0]           prdata;
        logic                  pslverr;
    } aso_state_t;

endpackage

/* File: rtl/aso_formatter.sv */
// sample formatter: code format and output resolution of one channel
`timescale 1ns/1ps
`include "aso_defs.svh"

module aso_formatter #(
    parameter int SAMPLE_W = 16
) (
    input  wire logic [SAMPLE_W-1:0] sample,
    input  wire logic [1:0]          res,
    input  wire logic                ofs_bin,
    output logic [`ASO_WORD_W-1:0]   word
);

    if (SAMPLE_W != 16) begin : g_bad
        $error("formatter serves 16-bit samples only");
    end

    logic [`ASO_WORD_W-1:0] full;

    // word is left aligned; the serializer sends its top bits only
    always_comb begin
        full = {sample, 4'h0}; // RULE_16 RULE_20
        if (res == `ASO_RES_14) begin
            full = full & 20'hFFFC0; // RULE_20
        end
        // offset binary is two's complement with the sign bit flipped
        word = full;
        word[`ASO_WORD_W-1] = full[`ASO_WORD_W-1] ^ ofs_bin; // RULE_14 RULE_15
    end

endmodule

/* File: rtl/aso_top.sv */
// serial output interface of a dual-channel converter, sync and registers
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "aso_defs.svh"
////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE_01 - combined pin powers down unless the sync-pin enable bit is set
// RULE_02 - sync pin is sampled on the rising sampling clock edge
// RULE_03 - sync comes from the command register or the pin
// RULE_04 - sync resets decimation dividers and aligns I and Q words
// RULE_05 - sync also restarts oscillator phase, like the mixer restart bit
// RULE_06 - host toggles sync only at multiples of 64 clocks
// RULE_07 - complex decimation: frame per N samples, two words per channel
// RULE_08 - real decimation: frame per M samples, halved in two-lane mode
// RULE_09 - lane modes: two lanes, one lane, half lane per channel
// RULE_10 - host supplies serial clock, frequency-locked to sampling clock
// RULE_11 - default mode launches bits on both bit clock edges
// RULE_12 - single-rate mode launches bits on bit clock rising edges only
// RULE_13 - single-rate mode halves the serial clock internally
// RULE_14 - two's complement by default, offset binary when configured
// RULE_15 - full-scale codes follow the chosen format and resolution
// RULE_16 - 16-bit sample reformatted to 14, 16, 18 or 20 bits
// RULE_17 - serialization length follows resolution and lane mode
// RULE_18 - host keeps the output rate within the interface maximum
// RULE_19 - output resolution resets to 18 bits
// RULE_20 - 14-bit drops low bits, wider widths pad low bits with zeros
// RULE_21 - pin sync acts once per low-to-high transition
////////////////////////////////////////////////////////////////////////////

module aso_top #(
    parameter int DEC_LOG_MAX = 5
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        powerdown_or_align_pin,
    input  wire logic [15:0] sample_a,
    input  wire logic [15:0] sample_b,
    input  wire logic        sample_valid,
    input  wire logic        serial_clock_input,
    output logic             returned_bit_clock,
    output logic             frame_clock,
    output logic [3:0]       output_data_lanes,
    output logic             powerdown,
    output logic             sync_event,
    output logic             nco_restart,
    output logic             decim_phase_zero
);

    if (DEC_LOG_MAX < 1 || DEC_LOG_MAX > 5) begin : g_bad
        $error("DEC_LOG_MAX must lie in 1..5");
    end

    aso_pkg::aso_state_t st_reg;
    aso_pkg::aso_state_t st_next;

    logic [1:0][19:0] fmt;
    logic             sync_en;
    logic             sdr;
    logic             w2;
    logic             pin_edge;
    logic             wr_acc;
    logic             cmd_sync;
    logic             cmd_mix;
    logic             sync_ev;
    logic             st_clr;
    logic             tick;
    logic [1:0]       lmode;
    logic [2:0]       dlog;
    logic [4:0]       n_max;
    logic [6:0]       res_bits;
    logic [6:0]       ch_bits;
    logic [6:0]       fb;
    logic [6:0]       fbv;
    logic [1:0][79:0] cw;
    logic [3:0][79:0] built;
    logic [3:0][79:0] shv;

    genvar c;
    for (c = 0; c < 2; c++) begin : g_ch
        aso_formatter u_fmt (
            .sample  (c == 0 ? sample_a : sample_b),
            .res     (st_reg.ctrl[`ASO_CTRL_RES]),
            .ofs_bin (st_reg.ctrl[`ASO_CTRL_OFS_A + c]),
            .word    (fmt[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next  = st_reg;
        sync_en  = st_reg.ctrl[`ASO_CTRL_SYNC_EN];
        sdr      = st_reg.ctrl[`ASO_CTRL_SDR];
        lmode    = st_reg.ctrl[`ASO_CTRL_LANES];
        // I and Q share a frame, as do the two samples of two-lane mode
        w2       = (lmode == `ASO_LANE_TWO) ||
                   (st_reg.ctrl[`ASO_CTRL_DEC_EN] &&
                    st_reg.ctrl[`ASO_CTRL_CPLX]); // RULE_07 RULE_08
        dlog     = st_reg.ctrl[`ASO_CTRL_DEC_LOG];
        if (dlog > 3'(DEC_LOG_MAX)) begin
            dlog = 3'(DEC_LOG_MAX);
        end
        n_max    = 5'((6'h01 << dlog) - 6'h01);
        fbv      = st_reg.frame_bits;
        shv      = st_reg.sh;
        tick     = 1'b0;
        st_next.sync_p = 1'b0;
        st_next.nco_p  = 1'b0;

        // pin taken on every rising sampling clock edge while ce is high
        st_next.pin_q    = powerdown_or_align_pin; // RULE_02
        st_next.pin_prev = st_reg.pin_q;
        st_next.pd       = st_reg.pin_q & ~sync_en; // RULE_01
        pin_edge = sync_en & st_reg.pin_q & ~st_reg.pin_prev; // RULE_21

        // bus: read data is fixed in the setup cycle, writes in access
        wr_acc   = psel & penable & pwrite;
        cmd_sync = wr_acc && paddr == `ASO_OFS_CMD &&
                   pwdata[`ASO_CMD_SYNC];
        cmd_mix  = wr_acc && paddr == `ASO_OFS_CMD &&
                   pwdata[`ASO_CMD_MIX];
        st_clr   = wr_acc && paddr == `ASO_OFS_STATUS &&
                   pwdata[`ASO_ST_SEEN];
        if (psel && !penable) begin
            st_next.pslverr = 1'b0;
            st_next.prdata  = 32'h0000_0000;
            case (paddr)
                `ASO_OFS_CTRL: begin
                    st_next.prdata = {19'h0, st_reg.ctrl};
                end
                `ASO_OFS_CMD: begin
                    st_next.prdata = 32'h0000_0000;
                end
                `ASO_OFS_STATUS: begin
                    st_next.prdata = {19'h0, st_reg.div_cnt, 5'h00,
                                      st_reg.pd, st_reg.pin_q,
                                      st_reg.seen};
                end
                default: begin
                    st_next.pslverr = 1'b1;
                end
            endcase
        end

        // sync from either source; a new frame layout restarts the link
        sync_ev = pin_edge | cmd_sync; // RULE_03
        st_next.sync_p = sync_ev;
        st_next.nco_p  = sync_ev | cmd_mix; // RULE_05
        st_next.seen   = (st_reg.seen & ~st_clr) | sync_ev;
        if (wr_acc && paddr == `ASO_OFS_CTRL) begin
            st_next.ctrl     = pwdata[`ASO_CTRL_W-1:0];
            st_next.ser      = aso_pkg::ST_IDLE;
            st_next.bit_cnt  = 7'h00;
            st_next.word_cnt = 1'b0;
        end

        // divider modulo N; N divides 64, so 64-cycle resyncs keep phase
        if (sync_ev) begin
            st_next.div_cnt = 5'h00; // RULE_04 RULE_06
        end else if (st_reg.ctrl[`ASO_CTRL_DEC_EN]) begin
            st_next.div_cnt = (st_reg.div_cnt >= n_max) ? 5'h00 :
                              st_reg.div_cnt + 5'h01;
        end

        // collect one or two formatted words per channel into a frame
        if (sync_ev) begin
            st_next.word_cnt = 1'b0; // RULE_04
        end else if (sample_valid) begin
            st_next.coll[0][st_reg.word_cnt] = fmt[0];
            st_next.coll[1][st_reg.word_cnt] = fmt[1];
            if (w2 && !st_reg.word_cnt) begin
                st_next.word_cnt = 1'b1;
            end else begin
                st_next.word_cnt = 1'b0;
                st_next.hold     = st_next.coll;
                if (st_reg.ser == aso_pkg::ST_IDLE) begin
                    st_next.ser     = aso_pkg::ST_RUN;
                    st_next.bit_cnt = 7'h00;
                end
            end
        end

        // frame length in bits per lane
        res_bits = `ASO_RES_MIN +
                   {4'h0, st_reg.ctrl[`ASO_CTRL_RES], 1'b0}; // RULE_16
        ch_bits  = w2 ? (res_bits << 1) : res_bits;
        case (lmode) // RULE_09 RULE_17
            `ASO_LANE_TWO:  fb = res_bits;
            `ASO_LANE_ONE:  fb = ch_bits;
            `ASO_LANE_HALF: fb = ch_bits << 1;
            default:        fb = res_bits;
        endcase

        // lane order: 0 and 1 carry channel A, 2 and 3 channel B; half-lane mode sends both channels on lane 0
        for (int i = 0; i < 2; i++) begin
            cw[i] = {st_reg.hold[i][0], 60'h0} |
                    (w2 ? ({st_reg.hold[i][1], 60'h0} >> res_bits) :
                     80'h0);
        end
        built = '0;
        case (lmode) // RULE_09
            `ASO_LANE_TWO: begin
                built[0] = {st_reg.hold[0][0], 60'h0};
                built[1] = {st_reg.hold[0][1], 60'h0};
                built[2] = {st_reg.hold[1][0], 60'h0};
                built[3] = {st_reg.hold[1][1], 60'h0};
            end
            `ASO_LANE_ONE: begin
                built[0] = cw[0];
                built[2] = cw[1];
            end
            `ASO_LANE_HALF: begin
                built[0] = cw[0] | (cw[1] >> ch_bits);
            end
            default: begin
                built = '0;
            end
        endcase

        // serial clock comes from the host and is locked to clk
        st_next.sci_q = serial_clock_input; // RULE_10
        if (sdr) begin
            // halving the input adds no clock of latency: bit_clk toggles on the same clock edge that sees the rise
            if (serial_clock_input && !st_reg.sci_q) begin
                st_next.bit_clk = ~st_reg.bit_clk; // RULE_13
                tick            = ~st_reg.bit_clk; // RULE_12
            end
        end else begin
            st_next.bit_clk = serial_clock_input; // RULE_11
            tick = serial_clock_input ^ st_reg.sci_q; // RULE_11
        end

        if (st_reg.ser == aso_pkg::ST_RUN && tick) begin
            if (st_reg.bit_cnt == 7'h00) begin
                fbv = fb;
                shv = built;
                st_next.frame_bits = fb; // RULE_17
            end
            for (int i = 0; i < 4; i++) begin
                st_next.lanes[i] = shv[i][`ASO_SH_W-1];
                st_next.sh[i]    = {shv[i][`ASO_SH_W-2:0], 1'b0};
            end
            st_next.frm_clk = st_reg.bit_cnt < (fbv >> 1); // RULE_07
            st_next.bit_cnt = (st_reg.bit_cnt + 7'h01 == fbv) ? 7'h00 :
                              st_reg.bit_cnt + 7'h01; // RULE_17
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_reg      <= '0;
            st_reg.ctrl <= `ASO_CTRL_RESET; // RULE_19
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a held clock enable also holds the bus transfer
    assign pready             = ce;
    assign prdata             = st_reg.prdata;
    assign pslverr            = st_reg.pslverr;
    assign returned_bit_clock = st_reg.bit_clk;
    assign frame_clock        = st_reg.frm_clk;
    assign output_data_lanes  = st_reg.lanes;
    assign powerdown          = st_reg.pd;
    assign sync_event         = st_reg.sync_p;
    assign nco_restart        = st_reg.nco_p;
    assign decim_phase_zero   = st_reg.ctrl[`ASO_CTRL_DEC_EN] &&
                                st_reg.div_cnt == 5'h00;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_pin_rise;
        ce && !st_reg.pin_q ##1
        ce && st_reg.pin_q && st_reg.ctrl[`ASO_CTRL_SYNC_EN];
    endsequence

    sequence s_sdr_rise;
        ce && st_reg.ctrl[`ASO_CTRL_SDR] &&
        serial_clock_input && !st_reg.sci_q;
    endsequence

    a_pin_sync_event: assert property ( // RULE_21
        s_pin_rise |=> sync_event)
        else $error("pin rise did not give a sync event");
    a_sync_only_once: assert property ( // RULE_21
        ce && st_reg.pin_q && st_reg.pin_prev && !wr_acc
        |=> !sync_event)
        else $error("sync repeated while pin stays high");
    a_pd_default: assert property ( // RULE_01
        ce && !st_reg.ctrl[`ASO_CTRL_SYNC_EN]
        |=> powerdown == $past(st_reg.pin_q))
        else $error("power-down does not follow the pin");
    a_div_reset: assert property ( // RULE_04
        sync_event |-> st_reg.div_cnt == 5'h00 && !st_reg.word_cnt)
        else $error("dividers not reset by sync");
    a_nco_restart: assert property ( // RULE_05
        sync_event |-> nco_restart)
        else $error("sync did not restart the oscillator");
    a_res_default: assert property ( // RULE_19
        $rose(rstn) |-> st_reg.ctrl[`ASO_CTRL_RES] == `ASO_RES_18)
        else $error("resolution not 18 bits after reset");
    a_ddr_follow: assert property ( // RULE_11
        ce && !st_reg.ctrl[`ASO_CTRL_SDR]
        |=> returned_bit_clock == $past(serial_clock_input))
        else $error("bit clock does not follow serial clock");
    a_sdr_halve: assert property ( // RULE_13
        s_sdr_rise |=> returned_bit_clock != $past(st_reg.bit_clk))
        else $error("single-rate bit clock did not toggle");
    a_frame_len: assert property ( // RULE_17
        st_reg.ser == aso_pkg::ST_RUN |-> st_reg.bit_cnt < 7'h51 &&
        (st_reg.bit_cnt == 7'h00 || st_reg.bit_cnt < st_reg.frame_bits))
        else $error("bit counter beyond frame length");

endmodule

/* File: tb/aso_rx_model.sv */
// receiving-side model: free serial clock, lane-0 frame capture
`timescale 1ns/1ps

module aso_rx_model (
    input  wire logic   clk,
    input  wire logic   rstn,
    input  wire logic   sdr,
    input  wire logic   returned_bit_clock,
    input  wire logic   frame_clock,
    input  wire logic   lane,
    output logic        serial_clock_input,
    output logic [79:0] last_frame,
    output logic [6:0]  last_len,
    output int          frame_cnt
);
    logic [1:0]  div_reg;
    logic        rbc_reg;
    logic        fc_reg;
    logic [79:0] sh_reg;
    logic [6:0]  cnt_reg;
    logic        tick;

    initial begin
        serial_clock_input = 1'b0;
        div_reg = 2'h0;
    end

    // runs free and locked to clk; single rate needs it twice as fast
    always @(posedge clk) begin
        div_reg <= div_reg + 2'h1;
        if ((div_reg & (sdr ? 2'h1 : 2'h3)) == 2'h0)
            serial_clock_input <= ~serial_clock_input;
    end

    ////////////////////////////////////////////////////////////
    // a bit is taken on every bit-clock change, or on rises only
    assign tick = sdr ? (returned_bit_clock & ~rbc_reg)
                      : (returned_bit_clock ^ rbc_reg);

    always @(posedge clk) begin
        if (!rstn) begin
            rbc_reg <= 1'b0;
            fc_reg <= 1'b0;
            cnt_reg <= 7'h00;
            frame_cnt <= 0;
        end else begin
            rbc_reg <= returned_bit_clock;
            if (tick) begin
                fc_reg <= frame_clock;
                if (frame_clock && !fc_reg) begin
                    last_frame <= sh_reg;
                    last_len <= cnt_reg;
                    frame_cnt <= frame_cnt + 1;
                    sh_reg <= {79'h0, lane};
                    cnt_reg <= 7'h01;
                end else begin
                    sh_reg <= {sh_reg[78:0], lane};
                    cnt_reg <= cnt_reg + 7'h01;
                end
            end
        end
    end
endmodule

/* File: tb/adc_serial_output_sync_bench.sv */
// self-checking bench of the serial output block
`timescale 1ns/1ps
`include "aso_defs.svh"

module adc_serial_output_sync_bench;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        ce = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        pin = 1'b0;
    logic [15:0] sample_a = 16'h0;
    logic [15:0] sample_b = 16'h0;
    logic        sample_valid = 1'b0;
    logic        sci;
    logic        rbc;
    logic        frm;
    logic [3:0]  lanes;
    logic        powerdown;
    logic        sync_event;
    logic        nco_restart;
    logic        phase_zero;
    logic        sdr = 1'b0;
    logic        decim_on = 1'b0;
    logic [79:0] last_frame;
    logic [6:0]  last_len;
    logic [31:0] seed = 32'h0000_0038;
    int          frame_cnt;
    int          miscompares = 0;
    int          n_compared = 0;
    int          n_sync = 0;
    int          n_nco = 0;
    int          s_mark = 0;
    int          n_mark = 0;
    int          cyc = 0;

    always #2 clk = ~clk;

    aso_top DUT (.clk(clk), .rstn(rstn), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .powerdown_or_align_pin(pin), .sample_a(sample_a),
        .sample_b(sample_b), .sample_valid(sample_valid),
        .serial_clock_input(sci), .returned_bit_clock(rbc),
        .frame_clock(frm), .output_data_lanes(lanes),
        .powerdown(powerdown), .sync_event(sync_event),
        .nco_restart(nco_restart), .decim_phase_zero(phase_zero));

    aso_rx_model rx (.clk(clk), .rstn(rstn), .sdr(sdr),
        .returned_bit_clock(rbc), .frame_clock(frm), .lane(lanes[0]),
        .serial_clock_input(sci), .last_frame(last_frame),
        .last_len(last_len), .frame_cnt(frame_cnt));

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // top R bits of {sample, 0000}; offset binary flips the sign bit
    function automatic logic [19:0] fmt(logic [15:0] s, logic [1:0] rs,
                                        logic ob);
        logic [19:0] full;
        full = {s[15] ^ ob, s[14:0], 4'h0};
        return full >> (6 - 2 * rs);
    endfunction

    task automatic end_sim();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(string what, logic [79:0] exp, logic [79:0] got);
        n_compared++;
        if (exp !== got) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    ////////////////////////////////////////////////////////////
    task automatic apb(logic [11:0] a, logic w, logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (i == 50) begin
            miscompares++;
            end_sim();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(a, 1'b1, d, q, e);
    endtask

    task automatic rd_chk(string what, logic [11:0] a, logic [31:0] exp,
                          logic exp_err);
        logic [31:0] q;
        logic        e;
        apb(a, 1'b0, 32'h0, q, e);
        chk(what, 80'(exp), 80'(q));
        chk("slave error", 80'(exp_err), 80'(e));
    endtask

    // counts pulses since the previous call
    task automatic pulses(string what, int ds, int dn);
        repeat (64) @(posedge clk);
        chk({what, " sync"}, 80'(ds), 80'(n_sync - s_mark));
        chk({what, " nco"}, 80'(dn), 80'(n_nco - n_mark));
        s_mark = n_sync;
        n_mark = n_nco;
    endtask

    task automatic pin_set(logic v);
        while (cyc % 64 != 0)
            @(posedge clk);
        pin <= v;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (sync_event === 1'b1) begin
            n_sync++;
            if (decim_on)
                chk("divider phase", 80'h1, 80'(phase_zero));
        end
        if (nco_restart === 1'b1)
            n_nco++;
    end

    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        end_sim();
    end

    initial begin
        logic [1:0]  ln;
        logic [1:0]  rs;
        logic        ob;
        logic [6:0]  len;
        logic [31:0] r;
        logic [15:0] sa;
        logic [15:0] sb;
        logic [79:0] exp;
        logic [79:0] got;
        logic        cx;
        int          f0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        sample_valid <= 1'b1;
        rd_chk("ctrl reset", `ASO_OFS_CTRL, 32'h0000_0420, 1'b0);
        rd_chk("unmapped", 12'h00C, 32'h0, 1'b1);
        rd_chk("cmd read", `ASO_OFS_CMD, 32'h0, 1'b0);
        for (int i = 0; i < 14; i++) begin
            ln = 2'(i % 3);
            rs = 2'(i % 4);
            ob = i[2];
            cx = (i >= 12);
            r = xorshift();
            sa = (i == 0) ? 16'h7FFF : (i == 4) ? 16'h8000 : r[15:0];
            sb = (i == 0) ? 16'h8000 : (i == 4) ? 16'h0000 : r[31:16];
            sample_a <= sa;
            sample_b <= sb;
            sdr <= (i >= 6);
            wr(`ASO_OFS_CTRL, {22'h0, cx, cx, ob, ob, rs, ln, i >= 6, 1'b0});
            f0 = frame_cnt;
            for (int k = 0; k < 2000 && frame_cnt < f0 + 3; k++)
                @(posedge clk);
            if (frame_cnt < f0 + 3) begin
                miscompares++;
                end_sim();
            end
            len = 7'(14 + 2 * rs);
            exp = 80'(fmt(sa, rs, ob));
            if (ln == `ASO_LANE_HALF) begin
                exp = (exp << len) | 80'(fmt(sb, rs, ob));
                len = len * 7'h2;
            end
            // complex output: I then Q of channel A on one lane
            if (cx && ln == `ASO_LANE_ONE) begin
                exp = (exp << len) | exp;
                len = len * 7'h2;
            end
            got = last_frame & ((80'h1 << len) - 80'h1);
            chk("frame length", 80'(len), 80'(last_len));
            chk("lane bits", exp, got);
            if (ln == `ASO_LANE_HALF)
                chk("idle lanes", 80'h0, 80'(lanes[3:1]));
        end
        // a low enable must freeze the bit clock, frame clock and data lanes
        ce <= 1'b0;
        @(posedge clk);
        r = {26'h0, rbc, frm, lanes};
        repeat (8) @(posedge clk);
        chk("frozen outputs", 80'(r), 80'({26'h0, rbc, frm, lanes}));
        ce <= 1'b1;
        wr(`ASO_OFS_CTRL, 32'h0000_0520);
        decim_on <= 1'b1;
        pulses("quiet", 0, 0);
        pin_set(1'b1);
        pulses("pin powerdown", 0, 0);
        chk("powerdown", 80'h1, 80'(powerdown));
        pin_set(1'b0);
        pulses("pin low", 0, 0);
        wr(`ASO_OFS_CTRL, 32'h0000_0521);
        pin_set(1'b1);
        pulses("pin rise", 1, 1);
        chk("no powerdown", 80'h0, 80'(powerdown));
        pin_set(1'b0);
        pulses("pin fall", 0, 0);
        wr(`ASO_OFS_CMD, 32'h0000_0001);
        pulses("cmd sync", 1, 1);
        wr(`ASO_OFS_CMD, 32'h0000_0002);
        pulses("mixer", 0, 1);
        // decimation off keeps the divider at zero after the sync
        decim_on <= 1'b0;
        wr(`ASO_OFS_CTRL, 32'h0000_0421);
        wr(`ASO_OFS_CMD, 32'h0000_0001);
        rd_chk("seen", `ASO_OFS_STATUS, 32'h1, 1'b0);
        wr(`ASO_OFS_STATUS, 32'h0000_0001);
        rd_chk("seen clear", `ASO_OFS_STATUS, 32'h0, 1'b0);
        end_sim();
    end
endmodule
